// ### common/adcsp_pkg.sv
// Contract
// [RL1] chip select high aborts transfers, resets the port, releases serial out, ignores input.
// [RL2] serial input sampled on rising clock; serial output launched on falling clock.
// [RL3] serial clock idle 4096 or 256 master cycles, by select bit, resets the port.
// [RL4] reset pin, chip select toggle or long clock idle each recover the port.
// [RL5] first three input bits all equal mark a direct channel-data read.
// [RL6] after a direct read, commands are ignored until port reset.
// [RL7] direct read data starts at first transition; 24 or 32 transitions complete it.
// [RL8] master must finish a direct read before the next conversion-ready.
// [RL9] with chip select low the first output bit is presented before conversion-ready; here it appears one master cycle after conversion-ready falls.
// [RL10] second direct read in one conversion-ready frame returns zeros.
// [RL11] code 001 reads channel data after the command byte; 40 transitions in all.
// [RL12] register-format channel read is not corrupted by a conversion update.
// [RL13] code 010 reads registers from start address, incrementing with multiple flag, stops 09h.
// [RL14] code 011 writes registers from start address, incrementing with multiple flag, stops 09h.
// [RL15] output during the command byte is undefined; the master discards it.
// [RL16] reset command restores register defaults; running conversion result is marked invalid.
// [RL17] channel data is status plus three bytes, or three bytes, MSB first.
// [RL18] status byte holds new-data, overrange, low-supply flags and channel identifier.
// [RL19] start low lets the conversion finish, then standby or sleep by select bit.
// [RL20] power-down disables all analog and digital functions.
// [RL21] fixed-channel pair comes from its mux register; common input is not selectable.
// [RL22] new-data flag set when the result has been refreshed since the last read.
// [RL23] reading again before an update returns the old result and clears new-data.
// [RL24] serial clock and chip select are synchronised to count idle master cycles.
package adcsp_pkg;
	localparam int REG_COUNT = 10;
	localparam logic [3:0] REG_LAST = 4'h9;
	localparam logic [3:0] REG_FIRST_CONFIG = 4'h0;
	localparam logic [3:0] REG_SECOND_CONFIG = 4'h1;
	localparam logic [3:0] REG_FIXED_MUX = 4'h2;
	localparam logic [7:0] REG_RESET_VALUE = 8'h00;
	localparam int CFG_TOUT_SEL_BIT = 0;
	localparam int CFG_STAT_EN_BIT = 1;
	localparam int CFG_IDLE_SEL_BIT = 7;
	localparam logic [2:0] CMD_CH_READ = 3'h1;
	localparam logic [2:0] CMD_REG_READ = 3'h2;
	localparam logic [2:0] CMD_REG_WRITE = 3'h3;
	localparam logic [2:0] CMD_RESET = 3'h6;
	localparam logic [2:0] DIRECT_ZEROS = 3'h0;
	localparam logic [2:0] DIRECT_ONES = 3'h7;
	localparam logic [6:0] DIRECT_DETECT_EDGE = 7'h02;
	localparam logic [6:0] CMD_END_EDGE = 7'h07;
	localparam logic [6:0] DATA_START_EDGE = 7'h08;
	localparam logic [6:0] DIRECT_LEN_STATUS = 7'h20;
	localparam logic [6:0] DIRECT_LEN_DATA = 7'h18;
	localparam logic [6:0] CH_READ_LEN = 7'h28;
	localparam logic [2:0] FLAG_CLEAR_BIT = 3'h3;
	localparam int STAT_NEW_BIT = 7;
	localparam int STAT_OVF_BIT = 6;
	localparam int STAT_SUPPLY_BIT = 5;
	localparam logic [12:0] TOUT_LONG_CYCLES = 13'h1000;
	localparam logic [12:0] TOUT_SHORT_CYCLES = 13'h0100;
	typedef enum {
		ST_CMD,
		ST_DIRECT,
		ST_CH_READ,
		ST_REG_READ,
		ST_REG_WRITE,
		ST_IGNORE
	} adcsp_link_state_t;
endpackage

// ### core/adcsp_port.sv
`timescale 1ns/1ps
module adcsp_port #(
	parameter int NUM_REGS = adcsp_pkg::REG_COUNT
) (
	// system
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// serial link
	input wire logic i_spi_cs_n,
	input wire logic i_spi_sclk,
	input wire logic i_spi_mosi,
	output logic o_spi_miso,
	output logic o_spi_miso_oe_n,
	// conversion core
	input wire logic i_conv_valid,
	input wire logic [23:0] i_conv_data,
	input wire logic i_conv_overrange,
	input wire logic i_conv_low_supply,
	input wire logic [4:0] i_conv_channel_identifier,
	input wire logic i_conv_busy,
	output logic o_conversion_ready_n,
	// mode control
	input wire logic i_start,
	input wire logic i_power_down,
	output logic o_idle_standby,
	output logic o_idle_sleep,
	output logic o_powered_down,
	// register contents
	output logic [7:0] o_first_config_reg,
	output logic [7:0] o_second_config_reg,
	output logic [7:0] o_fixed_channel_mux_reg,
	output logic [3:0] o_fixed_pos_input,
	output logic [3:0] o_fixed_neg_input
);
	import adcsp_pkg::*;

	generate
		if (NUM_REGS != REG_COUNT) begin : g_bad_regs
			$error("adcsp_port: register count must match the address map");
		end
	endgenerate

	// ---------------- system domain state
	logic [7:0] regs_q [REG_COUNT];
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic cs_s1_q, cs_s2_q;
	logic busy_s1_q, busy_s2_q;
	logic wr_s1_q, wr_s2_q, wr_s3_q;
	logic rc_s1_q, rc_s2_q, rc_s3_q;
	logic dn_s1_q, dn_s2_q, dn_s3_q;
	logic [12:0] idle_cnt_q;
	logic abort_q;
	logic intf_rst_q;
	logic por_q;
	logic [31:0] res_q;
	logic [31:0] word_q;
	logic new_q;
	logic zero_q;
	logic invalid_q;
	logic conversion_ready_n_n_q;
	logic pd_q;
	logic standby_q, sleep_q;
	logic held_q, freeze_q;

	// ---------------- link domain state
	adcsp_link_state_t state_q;
	logic [6:0] rcnt_q;
	logic [6:0] fcnt_q;
	logic [7:0] shift_q;
	logic mul_q;
	logic [3:0] addr_q;
	logic busy_q;
	logic wr_flag_q, rc_flag_q, dn_flag_q;
	logic [7:0] wr_data_q;
	logic [3:0] wr_addr_q;

	// ---------------- configuration decode
	wire logic stat_en = regs_q[REG_FIRST_CONFIG][CFG_STAT_EN_BIT];
	wire logic tout_long = regs_q[REG_FIRST_CONFIG][CFG_TOUT_SEL_BIT];
	wire logic idle_sleep_sel = regs_q[REG_SECOND_CONFIG][CFG_IDLE_SEL_BIT];
	wire logic [12:0] tout_limit = tout_long ? TOUT_LONG_CYCLES : TOUT_SHORT_CYCLES;

	// interface reset: pin level or a registered system event, so it cannot glitch
	wire logic link_rst = i_spi_cs_n | intf_rst_q; // [RL1] [RL4]

	// ---------------- system domain: crossings and timeout
	wire logic sclk_edge = sclk_s2_q ^ sclk_s3_q;
	wire logic wr_event = wr_s2_q & ~wr_s3_q;
	wire logic rc_event = rc_s2_q & ~rc_s3_q;
	wire logic dn_event = dn_s2_q & ~dn_s3_q;
	wire logic idle_hit = ~cs_s2_q & (idle_cnt_q == tout_limit - 13'h0001);
	wire logic capture = i_conv_valid & ~pd_q;
	wire logic freeze = busy_s2_q;
	// a result landing under a frozen read was not seen by it, so that read keeps the flags
	wire logic unread = held_q | (capture & freeze);
	wire logic consumed = dn_event & ~unread;

	always_ff @(posedge i_sys_clk) begin
		sclk_s1_q <= i_spi_sclk; // [RL24]
		sclk_s2_q <= sclk_s1_q;
		sclk_s3_q <= sclk_s2_q;
		cs_s1_q <= i_spi_cs_n; // [RL24]
		cs_s2_q <= cs_s1_q;
		busy_s1_q <= busy_q;
		busy_s2_q <= busy_s1_q;
		wr_s1_q <= wr_flag_q;
		wr_s2_q <= wr_s1_q;
		wr_s3_q <= wr_s2_q;
		rc_s1_q <= rc_flag_q;
		rc_s2_q <= rc_s1_q;
		rc_s3_q <= rc_s2_q;
		dn_s1_q <= dn_flag_q;
		dn_s2_q <= dn_s1_q;
		dn_s3_q <= dn_s2_q;
		freeze_q <= freeze;
	end

	// idle count saturates at the limit so one silence gives one abort
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || cs_s2_q || sclk_edge) begin
			idle_cnt_q <= 13'h0000;
		end else if (idle_cnt_q < tout_limit) begin
			idle_cnt_q <= idle_cnt_q + 13'h0001; // [RL3]
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			abort_q <= 1'b0;
			intf_rst_q <= 1'b1;
			por_q <= 1'b1;
			pd_q <= 1'b0;
		end else begin
			abort_q <= idle_hit; // [RL3] [RL4]
			intf_rst_q <= abort_q | i_power_down; // [RL3] [RL20]
			por_q <= 1'b0;
			pd_q <= i_power_down; // [RL20]
		end
	end

	// ---------------- system domain: register file
	always_ff @(posedge i_sys_clk) begin
		for (int i = 0; i < REG_COUNT; i++) begin
			if (!i_resetn || rc_event) begin
				regs_q[i] <= REG_RESET_VALUE; // [RL16]
			end else if (wr_event && wr_addr_q == 4'(i)) begin
				regs_q[i] <= wr_data_q; // [RL14]
			end
		end
	end

	// ---------------- system domain: result, flags, conversion-ready
	// the presented word is held while the link reads it; a newer result waits in res_q
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			res_q <= 32'h00000000;
			word_q <= 32'h00000000;
			new_q <= 1'b0;
			zero_q <= 1'b0;
			invalid_q <= 1'b0;
			conversion_ready_n_n_q <= 1'b1;
			held_q <= 1'b0;
		end else begin
			// cleared one cycle late so a completion seen a cycle after release still sees it
			if (capture && freeze) begin
				held_q <= 1'b1; // [RL12] [RL22]
			end else if (dn_event || (!freeze && !freeze_q)) begin
				held_q <= 1'b0;
			end
			if (capture) begin
				res_q <= {3'h0, i_conv_channel_identifier, i_conv_data}; // [RL17] [RL18]
				res_q[STAT_OVF_BIT + 24] <= i_conv_overrange; // [RL18]
				res_q[STAT_SUPPLY_BIT + 24] <= i_conv_low_supply;
			end
			if (!freeze) begin
				word_q <= {new_q, res_q[30:0]}; // [RL12]
				word_q[STAT_NEW_BIT + 24] <= new_q; // [RL22]
			end
			// set wins over the read clearing it
			if (capture) begin
				new_q <= ~invalid_q; // [RL22] [RL16]
			end else if (consumed) begin
				new_q <= 1'b0; // [RL23]
			end
			if (capture) begin
				zero_q <= 1'b0;
			end else if (consumed) begin
				zero_q <= 1'b1; // [RL10]
			end
			if (rc_event && i_conv_busy) begin
				invalid_q <= 1'b1; // [RL16]
			end else if (capture) begin
				invalid_q <= 1'b0;
			end
			if (pd_q) begin
				conversion_ready_n_n_q <= 1'b1; // [RL20]
			end else if (capture) begin
				conversion_ready_n_n_q <= 1'b0;
			end else if (consumed) begin
				conversion_ready_n_n_q <= 1'b1;
			end
		end
	end

	// idle only once the running conversion has finished
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			standby_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			standby_q <= ~i_power_down & ~i_start & ~i_conv_busy & ~idle_sleep_sel; // [RL19]
			sleep_q <= ~i_power_down & ~i_start & ~i_conv_busy & idle_sleep_sel; // [RL19]
		end
	end

	// ---------------- link domain: command decode on rising edges
	wire logic [7:0] shift_d = {shift_q[6:0], i_spi_mosi}; // [RL2]
	wire logic [6:0] rcnt_inc = (rcnt_q == 7'h7F) ? rcnt_q : rcnt_q + 7'h01;
	wire logic byte_end = (rcnt_q[2:0] == 3'h7);
	wire logic [6:0] direct_len = stat_en ? DIRECT_LEN_STATUS : DIRECT_LEN_DATA;
	wire logic addr_stop = ~mul_q | (addr_q == REG_LAST);
	wire logic direct_seen = (state_q == ST_CMD) && (rcnt_q == DIRECT_DETECT_EDGE)
		&& (shift_d[2:0] == DIRECT_ZEROS || shift_d[2:0] == DIRECT_ONES);
	wire logic cmd_done = (state_q == ST_CMD) && (rcnt_q == CMD_END_EDGE);
	wire logic direct_end = (state_q == ST_DIRECT) && (rcnt_q == direct_len - 7'h01);
	wire logic ch_end = (state_q == ST_CH_READ) && (rcnt_q == CH_READ_LEN - 7'h01);
	wire logic wr_fire = (state_q == ST_REG_WRITE) && byte_end;
	wire logic rc_fire = cmd_done && (shift_d[7:5] == CMD_RESET);
	wire logic dn_fire = direct_end | ch_end;

	always_ff @(posedge i_spi_sclk or posedge link_rst) begin
		if (link_rst) begin
			state_q <= ST_CMD; // [RL1]
			rcnt_q <= 7'h00;
			shift_q <= 8'h00;
			mul_q <= 1'b0;
			addr_q <= 4'h0;
			busy_q <= 1'b0;
		end else begin
			rcnt_q <= rcnt_inc;
			shift_q <= shift_d;
			if (rcnt_q == 7'h00) begin
				busy_q <= 1'b1;
			end
			unique case (state_q)
				ST_CMD: begin
					if (direct_seen) begin
						state_q <= ST_DIRECT; // [RL5]
					end else if (cmd_done) begin
						mul_q <= shift_d[4];
						addr_q <= shift_d[3:0];
						busy_q <= (shift_d[7:5] == CMD_CH_READ);
						if (shift_d[7:5] == CMD_CH_READ) begin
							state_q <= ST_CH_READ; // [RL11]
						end else if (shift_d[7:5] == CMD_REG_READ) begin
							state_q <= ST_REG_READ; // [RL13]
						end else if (shift_d[7:5] == CMD_REG_WRITE) begin
							state_q <= ST_REG_WRITE; // [RL14]
						end else begin
							state_q <= ST_IGNORE;
						end
					end
				end
				ST_DIRECT: begin
					if (direct_end) begin
						state_q <= ST_IGNORE; // [RL6] [RL7]
						busy_q <= 1'b0;
					end
				end
				ST_CH_READ: begin
					if (ch_end) begin
						state_q <= ST_IGNORE; // [RL11]
						busy_q <= 1'b0;
					end
				end
				ST_REG_READ, ST_REG_WRITE: begin
					if (byte_end) begin
						if (addr_stop) begin
							state_q <= ST_IGNORE; // [RL13] [RL14]
						end else begin
							addr_q <= addr_q + 4'h1;
						end
					end
				end
				ST_IGNORE: begin
					busy_q <= 1'b0; // [RL6]
				end
			endcase
		end
	end

	// event flags survive chip select so a last-edge write is still seen;
	// each stays high for several link clocks, long enough for the two-flop crossing
	always_ff @(posedge i_spi_sclk or posedge por_q) begin
		if (por_q) begin
			wr_flag_q <= 1'b0;
			rc_flag_q <= 1'b0;
			dn_flag_q <= 1'b0;
			wr_data_q <= 8'h00;
			wr_addr_q <= 4'h0;
		end else begin
			if (wr_fire) begin
				wr_flag_q <= 1'b1;
				wr_data_q <= shift_d; // [RL14]
				wr_addr_q <= addr_q;
			end else if (rcnt_q[2:0] == FLAG_CLEAR_BIT) begin
				wr_flag_q <= 1'b0;
			end
			if (rc_fire) begin
				rc_flag_q <= 1'b1; // [RL16]
			end else if (rcnt_q[2:0] == FLAG_CLEAR_BIT) begin
				rc_flag_q <= 1'b0;
			end
			if (dn_fire) begin
				dn_flag_q <= 1'b1; // [RL22]
			end else if (rcnt_q[2:0] == FLAG_CLEAR_BIT) begin
				dn_flag_q <= 1'b0;
			end
		end
	end

	// ---------------- link domain: output launch on falling edges
	always_ff @(negedge i_spi_sclk or posedge link_rst) begin
		if (link_rst) begin
			fcnt_q <= 7'h00;
		end else if (fcnt_q != 7'h7F) begin
			fcnt_q <= fcnt_q + 7'h01; // [RL2]
		end
	end

	// word_q and the registers are quasi-static while read: word_q is frozen by busy,
	// registers only change after a completed write byte or a reset command
	wire logic [31:0] dir_word = stat_en ? word_q : {word_q[23:0], 8'h00};
	wire logic [4:0] dir_idx = 5'h1F - fcnt_q[4:0];
	wire logic dir_bit = ~zero_q & (fcnt_q < direct_len) & dir_word[dir_idx]; // [RL7] [RL10]
	wire logic [6:0] data_pos = fcnt_q - DATA_START_EDGE;
	wire logic data_phase = (fcnt_q >= DATA_START_EDGE);
	wire logic [4:0] ch_idx = 5'h1F - data_pos[4:0];
	wire logic ch_bit = data_phase & (fcnt_q < CH_READ_LEN) & word_q[ch_idx]; // [RL11] [RL17]
	wire logic [7:0] reg_byte = (addr_q <= REG_LAST) ? regs_q[addr_q] : 8'h00;
	wire logic reg_bit = data_phase & reg_byte[3'h7 - data_pos[2:0]]; // [RL13]

	// command-phase output reuses the direct path; the master ignores it there
	always_comb begin
		o_spi_miso = 1'b0;
		unique case (state_q)
			ST_CMD, ST_DIRECT: o_spi_miso = dir_bit; // [RL9] [RL15]
			ST_CH_READ: o_spi_miso = ch_bit;
			ST_REG_READ: o_spi_miso = reg_bit;
			ST_REG_WRITE, ST_IGNORE: o_spi_miso = 1'b0;
		endcase
		if (link_rst) begin
			o_spi_miso = 1'b0;
		end
	end

	assign o_spi_miso_oe_n = link_rst; // [RL1] [RL20]

	// ---------------- outputs
	assign o_conversion_ready_n = conversion_ready_n_n_q; // [RL8]
	assign o_idle_standby = standby_q;
	assign o_idle_sleep = sleep_q;
	assign o_powered_down = pd_q;
	assign o_first_config_reg = regs_q[REG_FIRST_CONFIG];
	assign o_second_config_reg = regs_q[REG_SECOND_CONFIG];
	assign o_fixed_channel_mux_reg = regs_q[REG_FIXED_MUX];
	// 4-bit fields address only the sixteen analog inputs
	assign o_fixed_pos_input = regs_q[REG_FIXED_MUX][7:4]; // [RL21]
	assign o_fixed_neg_input = regs_q[REG_FIXED_MUX][3:0]; // [RL21]
endmodule // adcsp_port

// ### tb/adcsp_port_props.sv
`timescale 1ns/1ps
module adcsp_port_props (
	// watched ports
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_spi_cs_n,
	input wire logic o_spi_miso,
	input wire logic o_spi_miso_oe_n,
	input wire logic i_conv_valid,
	input wire logic i_conv_busy,
	input wire logic o_conversion_ready_n,
	input wire logic i_start,
	input wire logic i_power_down,
	input wire logic o_idle_standby,
	input wire logic o_idle_sleep,
	input wire logic o_powered_down,
	input wire logic [7:0] o_second_config_reg,
	input wire logic [7:0] o_fixed_channel_mux_reg,
	input wire logic [3:0] o_fixed_pos_input,
	input wire logic [3:0] o_fixed_neg_input
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	// chip select is asynchronous, so allow it to settle first
	sequence s_deselected;
		i_spi_cs_n [*3];
	endsequence
	sequence s_idle_cause;
		!i_power_down && !i_start && !i_conv_busy && $stable(o_second_config_reg[7]);
	endsequence
	a_miso_released: assert property (s_deselected |-> o_spi_miso_oe_n)
		else $error("serial out driven while deselected");
	a_released_low: assert property (o_spi_miso_oe_n |-> !o_spi_miso)
		else $error("released serial out not low");
	a_ready_on_valid: assert property (i_conv_valid && !i_power_down |=> !o_conversion_ready_n)
		else $error("ready not low after new result");
	a_ready_held_low: assert property (i_spi_cs_n [*8] ##0 $fell(o_conversion_ready_n) ##1 (i_spi_cs_n && !i_power_down) [*4] |-> !o_conversion_ready_n)
		else $error("ready released without a read");
	a_pd_quiet: assert property (i_power_down [*3] |-> o_powered_down && o_conversion_ready_n && o_spi_miso_oe_n)
		else $error("activity during power-down");
	a_idle_split: assert property (s_idle_cause [*2] |-> o_idle_sleep == o_second_config_reg[7] && o_idle_standby != o_second_config_reg[7])
		else $error("idle mode does not follow select bit");
	a_busy_not_idle: assert property (i_conv_busy || i_start || i_power_down |=> !o_idle_standby && !o_idle_sleep)
		else $error("idle while converting");
	a_mux_split: assert property ($stable(o_fixed_channel_mux_reg) [*2] |-> {o_fixed_pos_input, o_fixed_neg_input} == o_fixed_channel_mux_reg)
		else $error("fixed pair differs from mux register");
endmodule // adcsp_port_props

// ### tb/adcsp_port_tb.sv
`timescale 1ns/1ps
bind adcsp_port adcsp_port_props adcsp_port_props_i (.i_sys_clk, .i_resetn, .i_spi_cs_n,
	.o_spi_miso, .o_spi_miso_oe_n, .i_conv_valid, .i_conv_busy, .o_conversion_ready_n, .i_start,
	.i_power_down, .o_idle_standby, .o_idle_sleep, .o_powered_down, .o_second_config_reg,
	.o_fixed_channel_mux_reg, .o_fixed_pos_input, .o_fixed_neg_input);
module adcsp_port_tb;
	logic i_sys_clk, i_resetn, i_conv_valid, i_conv_overrange, i_conv_low_supply;
	logic i_conv_busy, i_start, i_power_down;
	logic [23:0] i_conv_data;
	logic [4:0] i_conv_channel_identifier;
	wire logic i_spi_cs_n, i_spi_sclk, i_spi_mosi, o_spi_miso, o_spi_miso_oe_n;
	wire logic o_conversion_ready_n, o_idle_standby, o_idle_sleep, o_powered_down;
	wire logic [7:0] o_first_config_reg, o_second_config_reg, o_fixed_channel_mux_reg;
	wire logic [3:0] o_fixed_pos_input, o_fixed_neg_input;
	// released line toggles so a stale bit can never pass
	wire logic miso_line = o_spi_miso_oe_n ? i_sys_clk : o_spi_miso;
	int bad_count = 0;
	int n_checks = 0;
	int seed = 55;
	logic [63:0] rx;
	logic [31:0] exp_word;
	logic [15:0] v;
	logic [7:0] w;

	adcsp_port adcsp_port_i (.i_sys_clk, .i_resetn, .i_spi_cs_n, .i_spi_sclk, .i_spi_mosi,
		.o_spi_miso, .o_spi_miso_oe_n, .i_conv_valid, .i_conv_data, .i_conv_overrange,
		.i_conv_low_supply, .i_conv_channel_identifier, .i_conv_busy, .o_conversion_ready_n,
		.i_start, .i_power_down, .o_idle_standby, .o_idle_sleep, .o_powered_down,
		.o_first_config_reg, .o_second_config_reg, .o_fixed_channel_mux_reg,
		.o_fixed_pos_input, .o_fixed_neg_input);
	adcsp_spi_master adcsp_spi_master_i (.o_cs_n(i_spi_cs_n), .o_sclk(i_spi_sclk),
		.o_mosi(i_spi_mosi), .i_miso(miso_line));

	initial begin
		i_sys_clk = 1'b0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		if (bad_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// gap after each frame lets register updates cross back
	task automatic spi(input int n, input logic [63:0] tx, input bit keep = 1'b0);
		adcsp_spi_master_i.xfer(n, tx, keep, rx);
		repeat (8) @(negedge i_sys_clk);
	endtask

	task automatic conv(input logic busy);
		@(negedge i_sys_clk);
		i_conv_data = 24'($random(seed));
		{i_conv_overrange, i_conv_low_supply, i_conv_channel_identifier} = 7'($random(seed));
		i_start = 1'($random(seed));
		i_conv_busy = busy;
		i_conv_valid = 1'b1;
		@(negedge i_sys_clk);
		i_conv_valid = 1'b0;
		i_conv_busy = 1'b0;
		repeat (4) @(negedge i_sys_clk);
	endtask

	function automatic logic [31:0] ch_word(input logic fresh);
		return {fresh, i_conv_overrange, i_conv_low_supply, i_conv_channel_identifier, i_conv_data};
	endfunction

	initial begin
		#500000;
		bad_count++;
		results();
	end

	initial begin
		i_resetn = 1'b0;
		i_conv_valid = 1'b0;
		i_conv_overrange = 1'b0;
		i_conv_low_supply = 1'b0;
		i_conv_busy = 1'b0;
		i_start = 1'b0;
		i_power_down = 1'b0;
		i_conv_data = 24'h000000;
		i_conv_channel_identifier = 5'h00;
		repeat (10) @(negedge i_sys_clk);
		i_resetn = 1'b1;
		repeat (4) @(negedge i_sys_clk);
		chk({o_first_config_reg, o_second_config_reg, o_fixed_channel_mux_reg, o_conversion_ready_n}, {24'h0, 1'b1});
		v = 16'($random(seed));
		spi(32, {8'h70, 8'h02, v});
		chk({o_first_config_reg, o_second_config_reg, o_fixed_channel_mux_reg}, {8'h02, v});
		// command byte bits in rx are discarded
		spi(32, {8'h50, 24'h0});
		chk(rx[23:0], {8'h02, v});
		spi(16, {8'h42, 8'h0});
		chk(rx[7:0], v[7:0]);
		spi(24, {8'h59, 16'h0});
		chk(rx[15:0], 16'h0000);
		// direct reads start right after the result, well before the next one
		conv(1'b0);
		spi(32, 64'h0);
		chk(rx[31:0], ch_word(1'b1));
		spi(32, 64'hFFFFFFFF);
		chk(rx[31:0], 32'h0);
		conv(1'b0);
		spi(40, {8'h30, 32'h0});
		chk(rx[31:0], ch_word(1'b1));
		spi(40, {8'h30, 32'h0});
		chk(rx[31:0], ch_word(1'b0));
		fork
			spi(40, {8'h30, 32'h0});
			begin
				repeat (20) @(negedge i_sys_clk);
				exp_word = ch_word(1'b0);
				conv(1'b0);
			end
		join
		chk(rx[31:0], exp_word);
		spi(40, {8'h30, 32'h0});
		chk(rx[31:0], ch_word(1'b1));
		spi(12, {8'h62, 4'hF});
		chk(o_fixed_channel_mux_reg, v[7:0]);
		// undefined code decodes if the partial bits survive the idle gap
		for (int sel = 0; sel < 2; sel++) begin
			spi(16, {8'h60, 7'h0, sel[0]});
			spi(5, 64'h15, 1'b1);
			repeat (300) @(negedge i_sys_clk);
			w = 8'($random(seed));
			spi(16, {8'h61, w});
			chk(o_second_config_reg, sel ? v[15:8] : w);
			if (sel == 0)
				v[15:8] = w;
		end
		conv(1'b0);
		spi(24, 64'h0);
		chk(rx[23:0], i_conv_data);
		spi(48, {32'h0, 8'h61, 8'h5A});
		chk(o_second_config_reg, v[15:8]);
		@(negedge i_sys_clk);
		i_conv_busy = 1'b1;
		spi(8, 64'hC0);
		chk({o_first_config_reg, o_second_config_reg, o_fixed_channel_mux_reg}, 24'h0);
		conv(1'b1);
		spi(40, {8'h30, 32'h0});
		chk(rx[31:0], ch_word(1'b0));
		@(negedge i_sys_clk);
		i_power_down = 1'b1;
		conv(1'b0);
		chk({o_powered_down, o_conversion_ready_n, o_spi_miso_oe_n}, 3'h7);
		results();
	end
endmodule // adcsp_port_tb

// ### tb/adcsp_spi_master.sv
`timescale 1ns/1ps
module adcsp_spi_master (
	// link
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_mosi,
	input wire logic i_miso
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b0;
	end
	// mode 0, sclk runs only inside a frame at 32 ns
	task automatic xfer(input int n, input logic [63:0] tx, input bit keep, output logic [63:0] rx);
		rx = '0;
		if (o_cs_n) begin
			o_cs_n = 1'b0;
			#100;
		end
		for (int i = n - 1; i >= 0; i--) begin
			o_mosi = tx[i];
			#16;
			o_sclk = 1'b1;
			rx[i] = i_miso;
			#16;
			o_sclk = 1'b0;
		end
		#50;
		o_mosi = ~o_mosi;
		if (!keep) begin
			o_cs_n = 1'b1;
			#100;
		end
	endtask
endmodule // adcsp_spi_master
